// [rtl/secnt_pkg.sv]
// shared constants for the scan-sampled event counter block
package secnt_pkg;

  // ---------------------------------------------------------------
  // data widths
  // ---------------------------------------------------------------
  localparam int SECNT_CW = 16;           // present count width
  localparam int SECNT_NCH = 3;           // counter channels
  localparam int SECNT_AW = 8;            // decoded address bits

  // ---------------------------------------------------------------
  // channel numbering
  // ---------------------------------------------------------------
  localparam int SECNT_CH_UP = 0;         // up-counting variant
  localparam int SECNT_CH_DN = 1;         // down-counting variant
  localparam int SECNT_CH_UD = 2;         // up/down variant

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SECNT_OFS_INPUT = 8'h00;   // counter input levels
  localparam logic [7:0] SECNT_OFS_SCAN = 8'h04;    // scan trigger / scan count
  localparam logic [7:0] SECNT_OFS_PRESET = 8'h08;  // preset_value, one word per channel
  localparam logic [7:0] SECNT_OFS_COUNT = 8'h14;   // present_count, one word per channel
  localparam logic [7:0] SECNT_OFS_STATUS = 8'h20;  // comparison outputs

  // ---------------------------------------------------------------
  // input register field positions
  // ---------------------------------------------------------------
  localparam int SECNT_IN_UP_CNT = 0;     // up variant count_up_input
  localparam int SECNT_IN_UP_CLR = 1;     // up variant clear
  localparam int SECNT_IN_DN_CNT = 2;     // down variant count_down_input
  localparam int SECNT_IN_DN_LD = 3;      // down variant load_input
  localparam int SECNT_IN_UD_INC = 4;     // up/down count_up_input
  localparam int SECNT_IN_UD_DEC = 5;     // up/down count_down_input
  localparam int SECNT_IN_UD_CLR = 6;     // up/down clear
  localparam int SECNT_IN_UD_LD = 7;      // up/down load_input
  localparam int SECNT_IN_W = 8;

  // ---------------------------------------------------------------
  // status register field positions
  // ---------------------------------------------------------------
  localparam int SECNT_ST_UP_DONE = 0;
  localparam int SECNT_ST_DN_DONE = 1;
  localparam int SECNT_ST_ABOVE = 2;      // at_or_above_flag
  localparam int SECNT_ST_BELOW = 3;      // at_or_below_flag
  localparam int SECNT_ST_W = 4;

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [SECNT_CW-1:0] SECNT_COUNT_RST = 16'h0000;
  localparam logic [SECNT_CW-1:0] SECNT_COUNT_MAX = 16'hFFFF;
  localparam logic [SECNT_CW-1:0] SECNT_PRESET_RST = 16'h0000;
  localparam logic [SECNT_IN_W-1:0] SECNT_INPUT_RST = 8'h00;
  localparam logic [31:0] SECNT_SCAN_RST = 32'h0000_0000;
  localparam int SECNT_DUTY_FULL = 100;   // duty percentage full scale

endpackage : secnt_pkg

// [rtl/secnt_cell.sv]
// one edge-counting cell: sampled once per scan, clear beats load beats counting
`timescale 1ns/10ps
`default_nettype none
module secnt_cell
  import secnt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scan_in,
  input wire logic inc_in,
  input wire logic dec_in,
  input wire logic clear_in,
  input wire logic load_in,
  input wire logic [SECNT_CW-1:0] preset_in,
  output logic [SECNT_CW-1:0] count_out
);

  // ---------------------------------------------------------------
  // edge detection against the previous scan's sample
  // ---------------------------------------------------------------
  logic inc_prev;
  logic dec_prev;
  wire logic inc_edge;
  wire logic dec_edge;
  wire logic do_inc;
  wire logic do_dec;
  logic [SECNT_CW-1:0] next_count;

  // only off-to-on counts; steady levels give no edge
  assign inc_edge = inc_in & ~inc_prev;
  assign dec_edge = dec_in & ~dec_prev;
  // saturate so the count never wraps past its ends
  assign do_inc = inc_edge & ~dec_edge & (count_out != SECNT_COUNT_MAX);
  assign do_dec = dec_edge & ~inc_edge & (count_out != SECNT_COUNT_RST);

  // ---------------------------------------------------------------
  // next count selection
  // ---------------------------------------------------------------
  always_comb begin
    next_count = count_out;
    if (clear_in) begin
      next_count = SECNT_COUNT_RST;
    end else if (load_in) begin
      next_count = preset_in;
    end else if (do_inc) begin
      next_count = count_out + 16'h0001;
    end else if (do_dec) begin
      next_count = count_out - 16'h0001;
    end
  end

  // samples and count move only on a scan
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      inc_prev <= 1'b0;
      dec_prev <= 1'b0;
      count_out <= SECNT_COUNT_RST;
    end else if (scan_in) begin
      inc_prev <= inc_in;
      dec_prev <= dec_in;
      count_out <= next_count;
    end
  end

endmodule : secnt_cell
`default_nettype wire

// [rtl/secnt_top.sv]
// scan-sampled event counters with an apb register slave
// ---------------------------------------------------------------
// What this block does
// - a count steps only on an off-to-on edge of a counting input, never on a level; clear and load act on levels.
// - three variants exist: up-counting, down-counting and combined up/down.
// - the up variant has count-up, clear and preset inputs and advances on each count-up edge.
// - the up variant's done turns on once its count reaches the preset.
// - the up variant's clear forces the count to zero and turns done off.
// - the down variant has count-down, load and preset inputs and decreases on each edge.
// - the down variant's done turns on once its count reaches zero.
// - the down variant's load copies the preset into the count and turns done off.
// - the up/down variant takes increment, decrement, clear, load and preset.
// - the up/down variant's clear sets its count to zero.
// - the up/down variant's load sets its count to the preset.
// - the up/down count rises by one per increment edge and falls by one per decrement edge.
// - at-or-above is on when count >= preset, at-or-below when count <= preset.
// - the fastest countable rate is duty/100 times one over the scan period.
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module secnt_top
  import secnt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic up_done_out,
  output logic dn_done_out,
  output logic at_or_above_flag_out,
  output logic at_or_below_flag_out,
  output logic scan_pulse_out
);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic [SECNT_AW-1:0] addr;
  wire logic access;
  wire logic commit;
  wire logic wr_commit;
  wire logic hit_input;
  wire logic hit_scan;
  wire logic hit_status;
  wire logic [SECNT_NCH-1:0] hit_preset;
  wire logic [SECNT_NCH-1:0] hit_count;
  wire logic hit_any;
  wire logic high_zero;

  assign addr = paddr_in[SECNT_AW-1:0];
  // upper address bits must be clear for any register to match
  assign high_zero = (paddr_in[31:SECNT_AW] == 24'h000000);
  assign access = psel_in & penable_in;
  // answer one cycle into the access phase; commit is the sampling edge
  assign commit = access & pready_out;
  assign wr_commit = commit & pwrite_in & hit_any;
  assign hit_input = high_zero & (addr == SECNT_OFS_INPUT);
  assign hit_scan = high_zero & (addr == SECNT_OFS_SCAN);
  assign hit_status = high_zero & (addr == SECNT_OFS_STATUS);

  // one preset word and one count word per channel
  genvar gi;
  generate
    for (gi = 0; gi < SECNT_NCH; gi++) begin : g_hit
      assign hit_preset[gi] = high_zero & (addr == SECNT_OFS_PRESET + 8'(4 * gi));
      assign hit_count[gi] = high_zero & (addr == SECNT_OFS_COUNT + 8'(4 * gi));
    end
  endgenerate

  assign hit_any = hit_input | hit_scan | hit_status | (|hit_preset) | (|hit_count);

  // ---------------------------------------------------------------
  // software-written state
  // ---------------------------------------------------------------
  logic [SECNT_IN_W-1:0] inputs;
  logic [SECNT_CW-1:0] preset [SECNT_NCH];
  logic [31:0] scan_count;
  logic scan_req;

  // input levels stand until rewritten; a level held until the next scan is
  // the program's job, a shorter pulse can simply be missed
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      inputs <= SECNT_INPUT_RST;
    end else if (wr_commit && hit_input) begin
      inputs <= pwdata_in[SECNT_IN_W-1:0];
    end
  end

  // preset words, one per channel
  generate
    for (gi = 0; gi < SECNT_NCH; gi++) begin : g_preset
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          preset[gi] <= SECNT_PRESET_RST;
        end else if (wr_commit && hit_preset[gi]) begin
          preset[gi] <= pwdata_in[SECNT_CW-1:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // scan strobe
  // ---------------------------------------------------------------
  // writing bit 0 of the scan word runs one scan a cycle later; the scan
  // rate therefore caps the countable pulse rate at duty/100 per scan
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scan_req <= 1'b0;
    end else begin
      scan_req <= wr_commit & hit_scan & pwdata_in[0];
    end
  end

  // number of scans run, readable for rate bookkeeping
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scan_count <= SECNT_SCAN_RST;
    end else if (scan_req) begin
      scan_count <= scan_count + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // per-channel input mapping
  // ---------------------------------------------------------------
  wire logic [SECNT_NCH-1:0] ch_inc;
  wire logic [SECNT_NCH-1:0] ch_dec;
  wire logic [SECNT_NCH-1:0] ch_clr;
  wire logic [SECNT_NCH-1:0] ch_ld;
  wire logic [SECNT_CW-1:0] ch_count [SECNT_NCH];

  // up variant: count-up and clear only
  assign ch_inc[SECNT_CH_UP] = inputs[SECNT_IN_UP_CNT];
  assign ch_dec[SECNT_CH_UP] = 1'b0;
  assign ch_clr[SECNT_CH_UP] = inputs[SECNT_IN_UP_CLR];
  assign ch_ld[SECNT_CH_UP] = 1'b0;
  // down variant: count-down and load only
  assign ch_inc[SECNT_CH_DN] = 1'b0;
  assign ch_dec[SECNT_CH_DN] = inputs[SECNT_IN_DN_CNT];
  assign ch_clr[SECNT_CH_DN] = 1'b0;
  assign ch_ld[SECNT_CH_DN] = inputs[SECNT_IN_DN_LD];
  // up/down variant: all four inputs
  assign ch_inc[SECNT_CH_UD] = inputs[SECNT_IN_UD_INC];
  assign ch_dec[SECNT_CH_UD] = inputs[SECNT_IN_UD_DEC];
  assign ch_clr[SECNT_CH_UD] = inputs[SECNT_IN_UD_CLR];
  assign ch_ld[SECNT_CH_UD] = inputs[SECNT_IN_UD_LD];

  // ---------------------------------------------------------------
  // counter cells
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < SECNT_NCH; gi++) begin : g_cell
      secnt_cell u_cell (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .scan_in(scan_req),
        .inc_in(ch_inc[gi]),
        .dec_in(ch_dec[gi]),
        .clear_in(ch_clr[gi]),
        .load_in(ch_ld[gi]),
        .preset_in(preset[gi]),
        .count_out(ch_count[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // comparison outputs
  // ---------------------------------------------------------------
  wire logic next_up_done;
  wire logic next_dn_done;
  wire logic next_above;
  wire logic next_below;
  wire logic [SECNT_ST_W-1:0] status;

  // done follows the count; a held clear keeps done off even with a zero preset
  assign next_up_done = (ch_count[SECNT_CH_UP] >= preset[SECNT_CH_UP])
    & ~ch_clr[SECNT_CH_UP];
  // a held load keeps done off, otherwise a zero preset would leave it on
  assign next_dn_done = (ch_count[SECNT_CH_DN] == SECNT_COUNT_RST)
    & ~ch_ld[SECNT_CH_DN];
  assign next_above = (ch_count[SECNT_CH_UD] >= preset[SECNT_CH_UD]);
  assign next_below = (ch_count[SECNT_CH_UD] <= preset[SECNT_CH_UD]);

  // flags lag the count by one clock so every output is a flop
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      up_done_out <= 1'b0;
      dn_done_out <= 1'b0;
      at_or_above_flag_out <= 1'b0;
      at_or_below_flag_out <= 1'b0;
      scan_pulse_out <= 1'b0;
    end else begin
      up_done_out <= next_up_done;
      dn_done_out <= next_dn_done;
      at_or_above_flag_out <= next_above;
      at_or_below_flag_out <= next_below;
      scan_pulse_out <= scan_req;
    end
  end

  assign status = {at_or_below_flag_out, at_or_above_flag_out, dn_done_out, up_done_out};

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_input) begin
      rd_mux = {24'h000000, inputs};
    end else if (hit_scan) begin
      rd_mux = scan_count;
    end else if (hit_status) begin
      rd_mux = {28'h0000000, status};
    end else begin
      for (int i = 0; i < SECNT_NCH; i++) begin
        if (hit_preset[i]) begin
          rd_mux = {16'h0000, preset[i]};
        end
        if (hit_count[i]) begin
          rd_mux = {16'h0000, ch_count[i]};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  // one wait state: pready rises on the second access cycle and stays
  // one cycle; read data and error are captured with it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= access & ~pready_out;
      pslverr_out <= access & ~pready_out & ~hit_any;
      if (access && !pready_out && !pwrite_in) begin
        prdata_out <= rd_mux;
      end
    end
  end

endmodule : secnt_top
`default_nettype wire

// [test/secnt_props.sv]
// concurrent checks on the port behaviour of the counter block
`timescale 1ns/10ps
`default_nettype none
module secnt_props
  import secnt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic up_done_out,
  input wire logic dn_done_out,
  input wire logic at_or_above_flag_out,
  input wire logic at_or_below_flag_out,
  input wire logic scan_pulse_out
);
  // ---------------------------------------------------------------
  // bus answer and flag relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("pready stood longer than one cycle");
  a_ready_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready missing after the wait state");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside an access phase");
  a_err_unmapped: assert property (pready_out && paddr_in[31:8] != 24'h000000 |-> pslverr_out)
    else $error("unmapped address not refused");
  a_err_mapped_ok: assert property (pready_out && paddr_in == 32'h0000_0000 |-> !pslverr_out)
    else $error("mapped address refused");
  a_err_data_zero: assert property (pready_out && pslverr_out && !pwrite_in
    |-> prdata_out == 32'h0000_0000)
    else $error("refused read returned data");
  a_status_upper_zero: assert property (pready_out && !pwrite_in
    && paddr_in == 32'h0000_0020 |-> prdata_out[31:4] == 28'h0000000)
    else $error("status upper bits not zero");
  a_scan_single: assert property (scan_pulse_out |=> !scan_pulse_out)
    else $error("scan pulse longer than one cycle");
  // a committed scan write must show its pulse two edges later
  a_scan_follows: assert property (pready_out && psel_in && penable_in && pwrite_in
    && paddr_in == 32'h0000_0004 && pwdata_in[0] |-> ##2 scan_pulse_out)
    else $error("scan write gave no scan pulse");
  // a count is always either at-or-above or at-or-below its preset; the
  // flags still hold their reset zeros at the first edge after release
  a_flags_cover_all: assert property (rst_n_in && $past(rst_n_in)
    |-> at_or_above_flag_out || at_or_below_flag_out)
    else $error("neither comparison flag on");
endmodule : secnt_props

bind secnt_top secnt_props i_props (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .up_done_out, .dn_done_out,
  .at_or_above_flag_out, .at_or_below_flag_out, .scan_pulse_out);
`default_nettype wire

// [test/secnt_prog_model.sv]
// control program model: reaches the counters over the register bus
`timescale 1ns/10ps
`default_nettype none
module secnt_prog_model (
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  output var logic psel_out,
  output var logic penable_out,
  output var logic pwrite_out,
  output var logic [31:0] paddr_out,
  output var logic [31:0] pwdata_out
);
  // ---------------------------------------------------------------
  // idle bus at time zero
  // ---------------------------------------------------------------
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 32'h0000_0000;
    pwdata_out = 32'h0000_0000;
  end

  // one transfer; the caller writes each input level once per scan so
  // every level is held across a whole scan period
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    // pready is read as it stood at each rising edge; no wait count is assumed
    do begin
      @(posedge clk_in);
    end while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released lines stop showing the old value
    paddr_out <= ~paddr_out;
    pwdata_out <= ~pwdata_out;
  endtask : xfer
endmodule : secnt_prog_model
`default_nettype wire

// [test/secnt_top_bench.sv]
// self-checking bench for the scan-sampled counter block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module secnt_top_bench
  import secnt_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  wire logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  wire logic up_done_out, dn_done_out, at_or_above_flag_out, at_or_below_flag_out, scan_pulse_out;
  wire logic [31:0] paddr_in, pwdata_in, prdata_out;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] rdat;
  logic rerr;
  typedef struct packed {
    logic [7:0] inp;
    logic [15:0] up, dn, ud;
    logic [3:0] st;
  } secnt_row_s;
  // input levels per scan and the counts and status they must leave
  secnt_row_s rows [12] = '{
    '{8'h08, 16'h0000, 16'h0003, 16'h0000, 4'h8}, '{8'h15, 16'h0001, 16'h0002, 16'h0001, 4'hC},
    '{8'h15, 16'h0001, 16'h0002, 16'h0001, 4'hC}, '{8'h00, 16'h0001, 16'h0002, 16'h0001, 4'hC},
    '{8'h25, 16'h0002, 16'h0001, 16'h0000, 4'h9}, '{8'h00, 16'h0002, 16'h0001, 16'h0000, 4'h9},
    '{8'h05, 16'h0003, 16'h0000, 16'h0000, 4'hB}, '{8'h10, 16'h0003, 16'h0000, 16'h0001, 4'hF},
    '{8'h00, 16'h0003, 16'h0000, 16'h0001, 4'hF}, '{8'h30, 16'h0003, 16'h0000, 16'h0001, 4'hF},
    '{8'hC2, 16'h0000, 16'h0000, 16'h0000, 4'hA}, '{8'h80, 16'h0000, 16'h0000, 16'h0001, 4'hE}};

  secnt_prog_model i_prog (.clk_in, .pready_in(pready_out), .pslverr_in(pslverr_out),
    .prdata_in(prdata_out), .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in));
  secnt_top i_dut (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .up_done_out, .dn_done_out,
    .at_or_above_flag_out, .at_or_below_flag_out, .scan_pulse_out);

  // ---------------------------------------------------------------
  // bus helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] ad(input logic [7:0] o);
    return {24'h000000, o};
  endfunction : ad
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_prog.xfer(1'b1, a, d, rdat, rerr);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    i_prog.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
  endtask : rd
  // flags settle two edges after the scan lands, so a short pause suffices
  task automatic scan(input logic [7:0] inp);
    wr(ad(SECNT_OFS_INPUT), {24'h000000, inp});
    wr(ad(SECNT_OFS_SCAN), 32'h0000_0001);
    repeat (2) @(posedge clk_in);
    `CHK("scan pulse", 1'b1, scan_pulse_out)
    @(posedge clk_in);
    `CHK("scan pulse end", 1'b0, scan_pulse_out)
  endtask : scan
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // clock, watchdog, tests
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK("reset flags", 4'hF, {at_or_below_flag_out, at_or_above_flag_out, dn_done_out, up_done_out})
    for (int a = 0; a < 32; a += 4) begin
      rd(a);
      `CHK("reset reg", 32'h0000_0000, rdat)
    end
    $display("test reset done");
    wr(ad(SECNT_OFS_PRESET), 32'h0000_0002);
    wr(ad(SECNT_OFS_PRESET) + 4, 32'h0000_0003);
    wr(ad(SECNT_OFS_PRESET) + 8, 32'h0000_0001);
    foreach (rows[i]) begin
      scan(rows[i].inp);
      rd(ad(SECNT_OFS_COUNT));
      `CHK("count up", {16'h0000, rows[i].up}, rdat)
      rd(ad(SECNT_OFS_COUNT) + 4);
      `CHK("count down", {16'h0000, rows[i].dn}, rdat)
      rd(ad(SECNT_OFS_COUNT) + 8);
      `CHK("count updown", {16'h0000, rows[i].ud}, rdat)
      rd(ad(SECNT_OFS_STATUS));
      `CHK("status", {28'h0000000, rows[i].st}, rdat)
      `CHK("flag pins", rows[i].st, {at_or_below_flag_out, at_or_above_flag_out, dn_done_out, up_done_out})
    end
    $display("test table done");
    // refused and read-only places
    rd(32'h0000_0100);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0000_0000, rdat)
    wr(ad(SECNT_OFS_COUNT), 32'h0000_0055);
    `CHK("ro write err", 1'b0, rerr)
    rd(ad(SECNT_OFS_COUNT));
    `CHK("ro count kept", 32'h0000_0000, rdat)
    $display("test refusal done");
    // a zero preset must still see done dropped by a held clear and load
    wr(ad(SECNT_OFS_PRESET), 32'h0000_0000);
    wr(ad(SECNT_OFS_PRESET) + 4, 32'h0000_0000);
    scan(8'h0A);
    `CHK("clear drops done", 1'b0, up_done_out)
    `CHK("load drops done", 1'b0, dn_done_out)
    $display("test zero preset done");
    // half duty toggling: one edge per two scans
    for (int i = 0; i < 10; i++) begin
      scan({7'h00, ~i[0]});
    end
    rd(ad(SECNT_OFS_COUNT));
    `CHK("rate count", 32'h0000_0005, rdat)
    rd(ad(SECNT_OFS_SCAN));
    `CHK("scan count", 32'h0000_0017, rdat)
    $display("test rate done");
    // a reset in mid-run must bring the flags, the scan total and the up/down count back
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    `CHK("rerun flags", 4'hF, {at_or_below_flag_out, at_or_above_flag_out, dn_done_out, up_done_out})
    rd(ad(SECNT_OFS_SCAN));
    `CHK("rerun scans", 32'h0000_0000, rdat)
    rd(ad(SECNT_OFS_COUNT) + 8);
    `CHK("rerun count", 32'h0000_0000, rdat)
    $display("test rerun done");
    complete_run();
  end
endmodule : secnt_top_bench
`undef CHK
`default_nettype wire
